// [verilog/usp_consts.svh]
/*
  constants of the spi-mode serial transceiver: mode codes, clock source
  codes, character length coding and timing counts.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef USP_CONSTS_SVH
`define USP_CONSTS_SVH

`define USP_MODE_LIN_MASTER 4'h000A
`define USP_MODE_LIN_SLAVE 4'h000B
`define USP_MODE_SPI_MASTER 4'h000E
`define USP_MODE_SPI_SLAVE 4'h000F

`define USP_CLKSRC_MAIN 2'h0
`define USP_CLKSRC_DIV 2'h1
`define USP_CLKSRC_EXT 2'h3

`define USP_MAIN_DIV 8
`define USP_CHAR_BASE 4'h0005
`define USP_CHAR_NINE 4'h0009
`define USP_DATA_BITS 9
`define USP_FIFO_DEPTH 16
`define USP_CD_BITS 16

`endif

// [verilog/usp_pkg.sv]
/*
  types of the spi-mode serial transceiver.
  assumes usp_consts.svh on the include path.
*/
package usp_pkg;
  `include "usp_consts.svh"

  typedef enum logic [2:0] {
    MST_IDLE,
    MST_LEAD,
    MST_SHIFT,
    MST_TRAIL,
    MST_GAP
  } usp_mst_state_t;

  typedef logic [3:0] usp_mode_t;
  typedef logic [1:0] usp_clksrc_t;
endpackage

// [verilog/usp_fifo.sv]
/*
  synchronous fifo with valid and ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module usp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("usp_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule

// [verilog/usp_core.sv]
/*
  spi master/slave mode of a serial transceiver: transmit fifo, transmit and
  receive holding registers, shifter, select line and status flags.
  assumes all inputs synchronous to clk; control bits and commands as ports.
*/
`timescale 1ns/10ps
`include "usp_consts.svh"
module usp_core #(
  parameter int DATA_W = `USP_DATA_BITS,
  parameter int FIFO_DEPTH = `USP_FIFO_DEPTH,
  parameter int CD_W = `USP_CD_BITS,
  parameter int MAIN_DIV = `USP_MAIN_DIV
) (
  input wire logic clk,
  input wire logic reset,
  input wire usp_pkg::usp_mode_t mode_field,
  input wire usp_pkg::usp_clksrc_t clock_source_select,
  input wire logic clock_output_enable,
  input wire logic [CD_W-1:0] clock_divider,
  input wire logic [1:0] char_length_field,
  input wire logic nine_bit_select,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic inhibit_until_read,
  input wire logic tx_enable_cmd,
  input wire logic tx_disable_cmd,
  input wire logic tx_reset_cmd,
  input wire logic rx_enable_cmd,
  input wire logic rx_disable_cmd,
  input wire logic rx_reset_cmd,
  input wire logic clear_status_cmd,
  input wire logic force_select_low_cmd,
  input wire logic release_select_cmd,
  input wire logic [DATA_W-1:0] tx_in_data,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire logic rx_read,
  output logic [DATA_W-1:0] receive_holding_reg,
  output logic rx_holding_full_flag,
  output logic overrun_flag,
  output logic underrun_flag,
  output logic tx_holding_empty_flag,
  output logic tx_all_done_flag,
  output logic rx_timeout_flag,
  output logic mode_reset_pending,
  output logic txd_o,
  output logic txd_oe,
  input wire logic rxd_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sck_i,
  output logic rts_o,
  input wire logic cts_i
);
  import usp_pkg::*;

  if (DATA_W != `USP_DATA_BITS || CD_W < 3 || MAIN_DIV < 1) begin : g_chk
    $error("usp_core needs nine data bits, a divider of 3+ bits and a positive divide");
  end

  // mode decode
  logic is_master;
  logic is_slave;
  assign is_master = (mode_field == `USP_MODE_SPI_MASTER);
  assign is_slave = (mode_field == `USP_MODE_SPI_SLAVE);

  // character length
  logic [3:0] nbits;
  assign nbits = nine_bit_select ? `USP_CHAR_NINE : (`USP_CHAR_BASE + {2'b00, char_length_field});

  // transmit fifo ahead of the holding register
  logic [DATA_W-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic fifo_ready;

  usp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_data(tx_in_data),
    .in_valid(tx_in_valid),
    .in_ready(fifo_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );
  assign tx_in_ready = fifo_ready;

  // enables
  logic tx_en_q;
  logic rx_en_q;

  always_ff @(posedge clk) begin
    if (reset || tx_reset_cmd || tx_disable_cmd) begin
      tx_en_q <= 1'b0;
    end else if (tx_enable_cmd) begin
      tx_en_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || rx_reset_cmd || rx_disable_cmd) begin
      rx_en_q <= 1'b0;
    end else if (rx_enable_cmd) begin
      rx_en_q <= 1'b1;
    end
  end

  // master bit timing
  logic [$clog2(MAIN_DIV+1)-1:0] pre_q;
  logic tick;
  logic [CD_W-1:0] cd_eff;
  logic [CD_W-1:0] ph_q;
  logic [CD_W-1:0] half;
  logic ph_last;
  usp_mst_state_t mst_q;

  assign tick = (clock_source_select == `USP_CLKSRC_DIV) ? (pre_q == ($bits(pre_q))'(MAIN_DIV - 1)) : 1'b1;
  assign cd_eff = (clock_divider == '0) ? CD_W'(1) : clock_divider;
  assign half = cd_eff >> 1;
  assign ph_last = tick && (ph_q == cd_eff - 1'b1);

  always_ff @(posedge clk) begin
    if (reset || clock_source_select != `USP_CLKSRC_DIV || pre_q == ($bits(pre_q))'(MAIN_DIV - 1)) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || mst_q == MST_IDLE || ph_last) begin
      ph_q <= '0;
    end else if (tick) begin
      ph_q <= ph_q + 1'b1;
    end
  end

  // holding register and start decisions
  logic [DATA_W-1:0] thr_q;
  logic thr_full_q;
  logic rx_full_q;
  logic mst_start;
  logic sl_busy_q;
  logic sl_load;
  logic thr_take;
  logic [3:0] bit_q;

  assign f_ready = tx_en_q && !thr_full_q;
  assign mst_start = is_master && mst_q == MST_IDLE && tx_en_q && thr_full_q
    && (!inhibit_until_read || !rx_full_q);
  assign sl_load = is_slave && !cts_i && !sl_busy_q;
  assign thr_take = mst_start || (sl_load && tx_en_q && thr_full_q);

  always_ff @(posedge clk) begin
    if (reset || tx_reset_cmd) begin
      thr_full_q <= 1'b0;
      thr_q <= '0;
    end else if (f_valid && f_ready) begin
      thr_full_q <= 1'b1;
      thr_q <= f_data;
    end else if (thr_take) begin
      thr_full_q <= 1'b0;
    end
  end

  // master sequencer
  always_ff @(posedge clk) begin
    if (reset || tx_reset_cmd || !is_master) begin
      mst_q <= MST_IDLE;
    end else begin
      case (mst_q)
        MST_IDLE: begin
          if (mst_start) begin
            mst_q <= MST_LEAD;
          end
        end
        MST_LEAD: begin
          if (ph_last) begin
            mst_q <= MST_SHIFT;
          end
        end
        MST_SHIFT: begin
          if (ph_last && bit_q == nbits - 1'b1) begin
            mst_q <= MST_TRAIL;
          end
        end
        MST_TRAIL: begin
          if (ph_last) begin
            mst_q <= MST_GAP;
          end
        end
        MST_GAP: begin
          if (ph_last) begin
            mst_q <= MST_IDLE;
          end
        end
        default: begin
          mst_q <= MST_IDLE;
        end
      endcase
    end
  end

  // slave edge detection on the sck pin
  logic sck_prev_q;
  logic sck_chg;
  logic sl_sample;
  logic sl_drive;
  logic m_sample;
  logic m_drive;
  logic sample_now;
  logic drive_now;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_i;
    end
  end

  assign sck_chg = (sck_i != sck_prev_q) && is_slave && sl_busy_q && !cts_i;
  assign sl_sample = sck_chg && ((sck_i != cpol) == cpha);
  assign sl_drive = sck_chg && ((sck_i != cpol) != cpha) && bit_q != '0;
  assign m_sample = mst_q == MST_SHIFT && tick && ph_q == half;
  assign m_drive = mst_q == MST_SHIFT && ph_last && bit_q != nbits - 1'b1;
  assign sample_now = m_sample || sl_sample;
  assign drive_now = m_drive || sl_drive;

  // slave character framing
  logic sl_done;
  assign sl_done = sl_sample && bit_q == nbits - 1'b1;

  always_ff @(posedge clk) begin
    if (reset || !is_slave || cts_i || sl_done) begin
      sl_busy_q <= 1'b0;
    end else if (sl_load) begin
      sl_busy_q <= 1'b1;
    end
  end

  // shift registers, msb first; transmit left aligned, receive right aligned
  logic [DATA_W-1:0] tx_sh_q;
  logic [DATA_W-1:0] rx_sh_q;
  logic [DATA_W-1:0] load_word;
  logic [3:0] pad;

  assign pad = 4'(DATA_W) - nbits;
  assign load_word = thr_q << pad;

  always_ff @(posedge clk) begin
    if (reset || tx_reset_cmd) begin
      tx_sh_q <= '1;
    end else if (mst_start) begin
      tx_sh_q <= load_word;
    end else if (sl_load) begin
      tx_sh_q <= (tx_en_q && thr_full_q) ? load_word : '1;
    end else if (drive_now) begin
      tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || mst_start || sl_load) begin
      bit_q <= '0;
    end else if (m_drive || (mst_q == MST_SHIFT && ph_last)) begin
      bit_q <= bit_q + 1'b1;
    end else if (sl_sample && !sl_done) begin
      bit_q <= bit_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_sh_q <= '0;
    end else if (mst_start || sl_load) begin
      rx_sh_q <= '0;
    end else if (sample_now) begin
      rx_sh_q <= {rx_sh_q[DATA_W-2:0], rxd_i};
    end
  end

  // receive completion
  logic rx_done;
  logic rx_pend_q;
  logic [DATA_W-1:0] rx_word;

  always_ff @(posedge clk) begin
    if (reset || mst_start) begin
      rx_pend_q <= 1'b0;
    end else begin
      rx_pend_q <= m_sample && bit_q == nbits - 1'b1;
    end
  end

  assign rx_done = rx_en_q && (rx_pend_q || sl_done);
  assign rx_word = sl_done ? {rx_sh_q[DATA_W-2:0], rxd_i} : rx_sh_q;

  always_ff @(posedge clk) begin
    if (reset || rx_reset_cmd) begin
      receive_holding_reg <= '0;
    end else if (rx_done) begin
      receive_holding_reg <= rx_word;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || rx_reset_cmd) begin
      rx_full_q <= 1'b0;
    end else if (rx_done) begin
      rx_full_q <= 1'b1;
    end else if (rx_read) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || rx_reset_cmd) begin
      overrun_flag <= 1'b0;
    end else if (rx_done && rx_full_q) begin
      overrun_flag <= 1'b1;
    end else if (clear_status_cmd) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || tx_reset_cmd) begin
      underrun_flag <= 1'b0;
    end else if (sl_load && tx_en_q && !thr_full_q) begin
      underrun_flag <= 1'b1;
    end else if (clear_status_cmd) begin
      underrun_flag <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_holding_full_flag <= 1'b0;
      tx_holding_empty_flag <= 1'b0;
      tx_all_done_flag <= 1'b0;
      rx_timeout_flag <= 1'b0;
    end else begin
      rx_holding_full_flag <= rx_full_q;
      tx_holding_empty_flag <= tx_en_q && !thr_full_q;
      tx_all_done_flag <= tx_en_q && !thr_full_q && !f_valid && mst_q == MST_IDLE && !sl_busy_q;
      rx_timeout_flag <= 1'b0;
    end
  end

  // select line forcing
  logic force_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      force_q <= 1'b0;
    end else if (force_select_low_cmd) begin
      force_q <= 1'b1;
    end else if (release_select_cmd) begin
      force_q <= 1'b0;
    end
  end

  // pins
  logic sck_active;
  assign sck_active = (mst_q == MST_SHIFT) && (cpha ? (ph_q >= half) : (ph_q < half));

  always_ff @(posedge clk) begin
    if (reset) begin
      txd_o <= 1'b1;
      txd_oe <= 1'b0;
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      rts_o <= 1'b1;
    end else begin
      txd_o <= (is_master && mst_q == MST_SHIFT) || (is_slave && sl_busy_q) ? tx_sh_q[DATA_W-1] : 1'b1;
      txd_oe <= is_master || is_slave;
      sck_o <= cpol ^ sck_active;
      sck_oe <= is_master && clock_output_enable;
      rts_o <= is_master ? !(force_q || mst_q == MST_LEAD || mst_q == MST_SHIFT || mst_q == MST_TRAIL) : 1'b1;
    end
  end

  // mode change tracking
  usp_mode_t mode_prev_q;
  logic first_cfg_q;
  logic mode_chg;
  logic node_mode;

  assign node_mode = is_master || is_slave || mode_field == `USP_MODE_LIN_MASTER
    || mode_field == `USP_MODE_LIN_SLAVE;
  assign mode_chg = (mode_field != mode_prev_q) && node_mode;

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_prev_q <= '0;
      first_cfg_q <= 1'b1;
    end else begin
      mode_prev_q <= mode_field;
      if (mode_chg) begin
        first_cfg_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reset_pending <= 1'b0;
    end else if (mode_chg && !first_cfg_q) begin
      mode_reset_pending <= 1'b1;
    end else if (tx_reset_cmd && rx_reset_cmd) begin
      mode_reset_pending <= 1'b0;
    end
  end
endmodule

// [test/usp_core_props.sv]
/*
  concurrent checks of the spi-mode transceiver core.
  assumes binding to usp_core; every input mirrors a port of that name.
*/
`timescale 1ns/10ps
`include "usp_consts.svh"
module usp_core_props (
  input wire logic clk,
  input wire logic reset,
  input wire usp_pkg::usp_mode_t mode_field,
  input wire logic cpol,
  input wire logic clear_status_cmd,
  input wire logic tx_reset_cmd,
  input wire logic rx_reset_cmd,
  input wire logic rts_o,
  input wire logic sck_o,
  input wire logic txd_oe,
  input wire logic overrun_flag,
  input wire logic underrun_flag,
  input wire logic rx_holding_full_flag,
  input wire logic rx_timeout_flag,
  input wire logic mode_reset_pending,
  input wire logic tx_in_ready
);
  import usp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic mst;
  assign mst = mode_field == `USP_MODE_SPI_MASTER;
  property p_no_timeout; !rx_timeout_flag; endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("receiver timeout raised");
  property p_pin_roles;
    $stable(mode_field) && !$past(reset) |-> txd_oe == (mst || mode_field == `USP_MODE_SPI_SLAVE);
  endproperty
  a_pin_roles: assert property (p_pin_roles) else $error("data output enable wrong for mode");
  property p_select_idle; (!mst) [*2] |-> rts_o; endproperty
  a_select_idle: assert property (p_select_idle) else $error("select driven outside master");
  property p_sck_idle; (mst && rts_o && $stable(cpol)) [*2] |-> sck_o == cpol; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not at idle level");
  property p_overrun_cause; $rose(overrun_flag) |-> $past(rx_holding_full_flag); endproperty
  a_overrun_cause: assert property (p_overrun_cause) else $error("overrun without full holding");
  property p_underrun_slave; $rose(underrun_flag) |-> mode_field == `USP_MODE_SPI_SLAVE; endproperty
  a_underrun_slave: assert property (p_underrun_slave) else $error("underrun outside slave");
  property p_clear; clear_status_cmd && mst && rts_o |-> ##[1:2] (!overrun_flag && !underrun_flag); endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  property p_pending; tx_reset_cmd && rx_reset_cmd && $stable(mode_field) |=> !mode_reset_pending; endproperty
  a_pending: assert property (p_pending) else $error("mode reset pending not cleared");
  c_frame: cover property ($fell(rts_o));
  c_overrun: cover property ($rose(overrun_flag));
  c_underrun: cover property ($rose(underrun_flag));
  c_full: cover property ($fell(tx_in_ready));
endmodule
bind usp_core usp_core_props u_props (.clk, .reset, .mode_field, .cpol, .clear_status_cmd, .tx_reset_cmd,
  .rx_reset_cmd, .rts_o, .sck_o, .txd_oe, .overrun_flag, .underrun_flag, .rx_holding_full_flag,
  .rx_timeout_flag, .mode_reset_pending, .tx_in_ready);

// [test/usp_spi_peer.sv]
/*
  behavioural spi slave peer facing the core in master mode.
  assumes sck, nss and mosi from the core, sampled on clk.
*/
`timescale 1ns/10ps
module usp_spi_peer (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic nss,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [3:0] nbits,
  input wire logic [8:0] tx_word,
  output logic miso,
  output logic [8:0] rx_word
);
  logic sck_q;
  logic nss_q;
  logic [8:0] sh;
  logic [8:0] al;
  logic [3:0] n;
  logic edge_seen;
  assign al = tx_word << (4'd9 - nbits);
  assign edge_seen = sck != sck_q;
  always_ff @(posedge clk) begin
    sck_q <= sck;
    nss_q <= nss;
    if (reset) begin
      miso <= 1'b0;
    end else if (nss) begin
      miso <= ~miso; // toggles every clock while deselected
    end else if (nss_q) begin
      sh <= cpha ? al << 1 : al;
      n <= '0;
      if (cpha) begin
        miso <= al[8];
      end
    end else if (edge_seen && ((sck_q == cpol) != cpha)) begin
      miso <= (n == nbits) ? al[8] : sh[8];
      sh <= (n == nbits) ? al << 1 : sh << 1;
      if (n == nbits) begin
        n <= '0;
      end
    end else if (edge_seen) begin
      rx_word <= {rx_word[7:0], mosi};
      n <= n + 1'b1;
    end
  end
endmodule

// [test/tb.sv]
/*
  self-checking bench of the spi-mode transceiver core.
  assumes usp_core, usp_spi_peer and the bound checker.
*/
`timescale 1ns/10ps
`include "usp_consts.svh"
module tb;
  import usp_pkg::*;
  localparam int CD = 6;
  logic clk, reset, clock_output_enable, nine_bit_select, cpol, cpha, inhibit_until_read;
  logic tx_enable_cmd, tx_disable_cmd, tx_reset_cmd, rx_enable_cmd, rx_disable_cmd, rx_reset_cmd;
  logic clear_status_cmd, force_select_low_cmd, release_select_cmd, tx_in_valid, tx_in_ready, rx_read;
  logic rx_holding_full_flag, overrun_flag, underrun_flag, tx_holding_empty_flag, tx_all_done_flag;
  logic rx_timeout_flag, mode_reset_pending, txd_o, txd_oe, rxd_i, sck_o, sck_oe, sck_i, rts_o, cts_i;
  logic rxd_tb, slv, miso_m;
  usp_mode_t mode_field;
  usp_clksrc_t clock_source_select;
  logic [15:0] clock_divider;
  logic [1:0] char_length_field;
  logic [8:0] tx_in_data, receive_holding_reg, stx, prx;
  logic [3:0] nb;
  int n_errors, checked, dv;
  assign rxd_i = slv ? rxd_tb : miso_m;
  usp_core DUT (.clk, .reset, .mode_field, .clock_source_select, .clock_output_enable, .clock_divider,
    .char_length_field, .nine_bit_select, .cpol, .cpha, .inhibit_until_read, .tx_enable_cmd, .tx_disable_cmd,
    .tx_reset_cmd, .rx_enable_cmd, .rx_disable_cmd, .rx_reset_cmd, .clear_status_cmd, .force_select_low_cmd,
    .release_select_cmd, .tx_in_data, .tx_in_valid, .tx_in_ready, .rx_read, .receive_holding_reg,
    .rx_holding_full_flag, .overrun_flag, .underrun_flag, .tx_holding_empty_flag, .tx_all_done_flag,
    .rx_timeout_flag, .mode_reset_pending, .txd_o, .txd_oe, .rxd_i, .sck_o, .sck_oe, .sck_i, .rts_o, .cts_i);
  usp_spi_peer peer (.clk, .reset, .sck(sck_o), .nss(rts_o), .mosi(txd_o), .cpol, .cpha, .nbits(nb),
    .tx_word(stx), .miso(miso_m), .rx_word(prx));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    n_errors++;
    stop_test();
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_lvl(input int s, input logic l);
    int i;
    for (i = 0; i < 3000 && (s == 0 ? rts_o : s == 1 ? tx_all_done_flag : overrun_flag) !== l; i++) tick(1);
    if (i >= 3000) hang();
  endtask
  task automatic push(input logic [8:0] w);
    int i;
    tx_in_data = w;
    tx_in_valid = 1'b1;
    for (i = 0; i < 3000 && tx_in_ready !== 1'b1; i++) tick(1);
    if (i >= 3000) hang();
    tick(1);
    tx_in_valid = 1'b0;
    tick(1);
  endtask
  task automatic scen_master(input logic p, input logic h, input logic q, input logic [1:0] cl,
      input logic [8:0] w);
    int c;
    logic [8:0] m;
    cpol = p;
    cpha = h;
    nine_bit_select = q;
    char_length_field = cl;
    nb = q ? 4'd9 : {2'b00, cl} + 4'd5;
    m = 9'h1FF >> (4'd9 - nb);
    stx = ~w;
    tick(2);
    push(w);
    wait_lvl(0, 1'b0);
    for (c = 0; c < 1000 && rts_o === 1'b0; c++) tick(1);
    if (dv == 1) chk(16'(c), 16'((nb + 2) * CD));
    else chk(16'(c > (nb + 2) * CD * dv - dv && c <= (nb + 2) * CD * dv), 16'h0001);
    tick(CD * dv);
    chk(sck_oe, 1);
    chk(txd_oe, 1);
    chk(prx & m, w & m);
    chk(receive_holding_reg, stx & m);
    chk(rx_holding_full_flag, 1);
    chk(tx_all_done_flag, 1);
    pulse(rx_read);
  endtask
  task automatic scen_queue;
    pulse(force_select_low_cmd);
    push(9'h03C);
    push(9'h0C3);
    wait_lvl(2, 1'b1);
    tick(2 * CD);
    chk(rts_o, 0);
    chk(receive_holding_reg, stx & 9'h0FF);
    pulse(release_select_cmd);
    tick(3);
    chk(rts_o, 1);
    pulse(clear_status_cmd);
    tick(3);
    chk(overrun_flag, 0);
  endtask
  task automatic scen_inhibit;
    inhibit_until_read = 1'b1;
    push(9'h05A);
    tick(12 * CD);
    chk(rts_o, 1);
    pulse(rx_read);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    inhibit_until_read = 1'b0;
    tick(CD);
    pulse(rx_read);
  endtask
  task automatic scen_fifo;
    int i;
    pulse(tx_disable_cmd);
    pulse(rx_disable_cmd);
    tick(2);
    chk(tx_holding_empty_flag, 0);
    chk(tx_all_done_flag, 0);
    for (i = 0; i < 16; i++) push(9'(i));
    tick(2);
    chk(tx_in_ready, 0);
    pulse(tx_enable_cmd);
    tick(2);
    wait_lvl(1, 1'b1);
    chk(tx_holding_empty_flag, 1);
    chk(tx_in_ready, 1);
    chk(rx_holding_full_flag, 0);
    chk(overrun_flag, 0);
    pulse(clear_status_cmd);
    pulse(rx_read);
    pulse(rx_enable_cmd);
  endtask
  task automatic scen_slave(input logic [8:0] w);
    int i;
    mode_field = `USP_MODE_SPI_SLAVE;
    clock_divider = 16'h0064;
    tick(2);
    chk(mode_reset_pending, 1);
    chk(sck_oe, 0);
    tx_reset_cmd = 1'b1;
    rx_reset_cmd = 1'b1;
    tick(1);
    tx_reset_cmd = 1'b0;
    rx_reset_cmd = 1'b0;
    tick(1);
    chk(mode_reset_pending, 0);
    pulse(tx_enable_cmd);
    pulse(rx_enable_cmd);
    cpol = 1'b0;
    cpha = 1'b1;
    nine_bit_select = 1'b0;
    char_length_field = 2'h3;
    slv = 1'b1;
    cts_i = 1'b0;
    tick(12);
    for (i = 7; i >= 0; i--) begin
      rxd_tb = w[i];
      tick(6);
      sck_i = 1'b1;
      tick(1);
      chk(txd_o, 1);
      tick(5);
      sck_i = 1'b0;
    end
    tick(6);
    cts_i = 1'b1;
    rxd_tb = ~rxd_tb;
    tick(3);
    chk(underrun_flag, 1);
    chk(receive_holding_reg, w);
    chk(rx_holding_full_flag, 1);
    mode_field = `USP_MODE_LIN_MASTER;
    tick(2);
    chk(mode_reset_pending, 1);
  endtask
  initial begin
    {tx_enable_cmd, tx_disable_cmd, tx_reset_cmd, rx_enable_cmd, rx_disable_cmd, rx_reset_cmd} = '0;
    {clear_status_cmd, force_select_low_cmd, release_select_cmd, tx_in_valid, rx_read, slv, sck_i} = '0;
    {nine_bit_select, cpol, cpha, inhibit_until_read, char_length_field, tx_in_data} = '0;
    reset = 1'b1;
    mode_field = `USP_MODE_SPI_MASTER;
    clock_source_select = `USP_CLKSRC_MAIN;
    clock_output_enable = 1'b1;
    dv = 1;
    clock_divider = 16'(CD);
    rxd_tb = 1'b1;
    cts_i = 1'b1;
    stx = '0;
    nb = 4'd8;
    n_errors = 0;
    checked = 0;
    tick(3);
    reset = 1'b0;
    chk(rts_o, 1);
    chk(txd_o, 1);
    chk(tx_holding_empty_flag, 0);
    pulse(tx_enable_cmd);
    pulse(rx_enable_cmd);
    scen_master(1'b0, 1'b1, 1'b0, 2'h3, 9'h0C3);
    scen_master(1'b0, 1'b0, 1'b0, 2'h0, 9'h015);
    scen_master(1'b1, 1'b1, 1'b0, 2'h1, 9'h02D);
    clock_source_select = `USP_CLKSRC_DIV;
    dv = `USP_MAIN_DIV;
    scen_master(1'b0, 1'b1, 1'b0, 2'h0, 9'h013);
    clock_source_select = `USP_CLKSRC_MAIN;
    dv = 1;
    scen_master(1'b1, 1'b0, 1'b1, 2'h2, 9'h15A);
    scen_queue();
    scen_inhibit();
    scen_fifo();
    scen_slave(9'h0A5);
    stop_test();
  end
endmodule
